// ==== hw/tws_conv.sv ====
// conversion timebase and result holder
`timescale 1ns/10ps
`default_nettype none
module tws_conv
  import tws_pkg::*;
#(
  parameter int unsigned      CONV_CYCLES  = CONV_CYC,
  parameter logic [3:0][31:0] PERIOD_CYCLES = PERIOD_CYC
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // control and front end
  input  wire logic [1:0] rate,
  input  wire logic [7:0] tempIn,
  // results
  output logic            measureOn,
  output logic [7:0]      tempOut
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [7:0]  temp_r;
  logic [7:0]  temp_nxt;

  // period length for a rate code
  function automatic logic [31:0] periodOf(input logic [1:0] r);
    periodOf = PERIOD_CYCLES[r];
  endfunction : periodOf

  // ****************************************************
  // convert first, then power down until period ends
  // ****************************************************
  always_comb
  begin
    cnt_nxt  = cnt_r + 32'h0000_0001;
    temp_nxt = temp_r;
    if (cnt_r == 32'(CONV_CYCLES - 1))
      temp_nxt = tempIn;
    if (cnt_r >= periodOf(rate) - 32'h0000_0001)
      cnt_nxt = 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r  <= 32'h0000_0000;
      temp_r <= 8'h00;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      temp_r <= temp_nxt;
    end
  end

  assign measureOn = cnt_r < 32'(CONV_CYCLES);
  assign tempOut   = temp_r;

  // measuring phase ends exactly at the conversion length
  property p_conv_len;
    @(posedge clk) disable iff (!reset_n)
    $fell(measureOn) |-> $past(cnt_r) == 32'(CONV_CYCLES - 1);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

endmodule : tws_conv
`default_nettype wire

// ==== hw/tws_pin_sync.sv ====
// pin synchroniser and bus condition detector
`timescale 1ns/10ps
`default_nettype none
module tws_pin_sync
  import tws_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // pins
  input  wire logic sclIn,
  input  wire logic sdaIn,
  // detected levels and events
  output logic      sclLvl,
  output logic      sdaLvl,
  output logic      sclRise,
  output logic      sclFall,
  output logic      startDet,
  output logic      stopDet
);
  logic [1:0] pin;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;

  assign pin = {sclIn, sdaIn};

  // ****************************************************
  // two flops per pin, then a history stage
  // ****************************************************
  for (genvar i = 0; i < 2; i++)
  begin : g_sync
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        s1_r[i] <= 1'b1;
        s2_r[i] <= 1'b1;
        s3_r[i] <= 1'b1;
      end
      else
      begin
        s1_r[i] <= pin[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
      end
    end
  end

  // edges and bus conditions from the synced copies
  assign sclLvl   = s2_r[1];
  assign sdaLvl   = s2_r[0];
  assign sclRise  = s2_r[1] & ~s3_r[1];
  assign sclFall  = ~s2_r[1] & s3_r[1];
  assign startDet = s2_r[1] & s3_r[1] & ~s2_r[0] & s3_r[0];
  assign stopDet  = s2_r[1] & s3_r[1] & s2_r[0] & ~s3_r[0];

endmodule : tws_pin_sync
`default_nettype wire

// ==== hw/tws_pkg.sv ====
// constants and types of the two-wire temperature sensor slave
//
// Contract
// - both lines released high means bus idle
// - SDA falling while SCL high starts transaction
// - SDA rising while SCL high is stop
// - any byte count between start and stop
// - addressed receiver acknowledges in ninth clock slot
// - acknowledge holds SDA low through clock high
// - all sensors acknowledge the broadcast byte
// - broadcast read gives up to eight slots
// - low three address bits fixed by variant
// - rate field 00..11 gives 0.25/1/4/8 per second
// - conversion about 26 ms, idle until period
// - temperature byte, one step per degree
package tws_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned CONV_TIME_US = 26000;
  localparam int unsigned TIMEOUT_US   = 30000;
  localparam int unsigned CONV_CYC     = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_CYC  = TIMEOUT_US * CLK_MHZ;
  // conversion periods in ms for rate codes 00..11, scalars for tool reach
  localparam int unsigned PERIOD_MS_0  = 4000;
  localparam int unsigned PERIOD_MS_1  = 1000;
  localparam int unsigned PERIOD_MS_2  = 250;
  localparam int unsigned PERIOD_MS_3  = 125;
  localparam logic [3:0][31:0] PERIOD_CYC = {
    32'(PERIOD_MS_3 * 1000 * CLK_MHZ), 32'(PERIOD_MS_2 * 1000 * CLK_MHZ),
    32'(PERIOD_MS_1 * 1000 * CLK_MHZ), 32'(PERIOD_MS_0 * 1000 * CLK_MHZ)};

  // ****************************************************
  // addressing and register layout
  // ****************************************************
  localparam logic [3:0] DEV_ADDR_HI            = 4'h9; // arbitrary value
  localparam logic [6:0] BROADCAST_GROUP_ACCESS = 7'h00;
  localparam logic [7:0] PTR_TEMP               = 8'h00;
  localparam logic [7:0] PTR_CFG                = 8'h01;
  localparam int unsigned RATE_SELECT_HIGH_BIT  = 6;
  localparam int unsigned RATE_SELECT_LOW_BIT   = 5;
  localparam logic [1:0] RATE_RESET             = 2'h0;
  localparam logic [3:0] SLOT_MAX               = 4'h8;

  // ****************************************************
  // link states
  // ****************************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_RX   = 7'h08,
    ST_RACK = 7'h10,
    ST_TX   = 7'h20,
    ST_TACK = 7'h40
  } tws_state_e;

endpackage : tws_pkg

// ==== hw/tws_slave.sv ====
// two-wire slave of the temperature sensor, top level
`timescale 1ns/10ps
`default_nettype none
module tws_slave
#(
  parameter logic [2:0]       VARIANT_ADDR  = 3'h0,
  parameter int unsigned      CONV_CYCLES   = tws_pkg::CONV_CYC,
  parameter int unsigned      TIMEOUT_CYCLES = tws_pkg::TIMEOUT_CYC,
  parameter logic [3:0][31:0] PERIOD_CYCLES = tws_pkg::PERIOD_CYC
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // two-wire pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // measurement front end
  input  wire logic [7:0] tempIn,
  output logic            measureOn,
  output logic [7:0]      tempValue,
  output logic [1:0]      rateSel
);
  import tws_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  logic       sclLvl;
  logic       sdaLvl;
  logic       sclRise;
  logic       sclFall;
  logic       startDet;
  logic       stopDet;
  logic       variantAddrBitZero;
  logic       variantAddrBitOne;
  logic       variantAddrBitTwo;
  logic [6:0] ownAddr;
  logic       tmoHit;

  tws_state_e  state_r;
  tws_state_e  state_nxt;
  logic [3:0]  bitCnt_r;
  logic [3:0]  bitCnt_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic        rw_r;
  logic        rw_nxt;
  logic        bcast_r;
  logic        bcast_nxt;
  logic        gotPtr_r;
  logic        gotPtr_nxt;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;
  logic [1:0]  rate_r;
  logic [1:0]  rate_nxt;
  logic [3:0]  slot_r;
  logic [3:0]  slot_nxt;
  logic [7:0]  txSh_r;
  logic [7:0]  txSh_nxt;
  logic        acked_r;
  logic        acked_nxt;
  logic        sdaOe_r;
  logic        sdaOe_nxt;
  logic [31:0] tmo_r;
  logic [31:0] tmo_nxt;

  // fixed low address bits of this variant
  assign variantAddrBitZero = VARIANT_ADDR[0];
  assign variantAddrBitOne  = VARIANT_ADDR[1];
  assign variantAddrBitTwo  = VARIANT_ADDR[2];
  assign ownAddr = {DEV_ADDR_HI, variantAddrBitTwo, variantAddrBitOne,
                    variantAddrBitZero};

  // byte returned for the current pointer
  function automatic logic [7:0] readByte(input logic [7:0] p, input logic [1:0] r,
                                          input logic [7:0] t);
    readByte = t;
    if (p == PTR_CFG)
    begin
      readByte = 8'h00;
      readByte[RATE_SELECT_HIGH_BIT] = r[1];
      readByte[RATE_SELECT_LOW_BIT]  = r[0];
    end
  endfunction : readByte

  // whether this sensor owns the current read slot
  function automatic logic ownsSlot(input logic b, input logic [3:0] s);
    ownsSlot = !b || (s == {1'b0, VARIANT_ADDR});
  endfunction : ownsSlot

  // ****************************************************
  // submodules
  // ****************************************************
  tws_pin_sync u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sclLvl   (sclLvl),
    .sdaLvl   (sdaLvl),
    .sclRise  (sclRise),
    .sclFall  (sclFall),
    .startDet (startDet),
    .stopDet  (stopDet)
  );

  tws_conv #(
    .CONV_CYCLES   (CONV_CYCLES),
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_conv (
    .clk       (clk),
    .reset_n   (reset_n),
    .rate      (rate_r),
    .tempIn    (tempIn),
    .measureOn (measureOn),
    .tempOut   (tempValue)
  );

  // ****************************************************
  // link state machine
  // ****************************************************
  assign tmoHit = (state_r != ST_IDLE) && (tmo_r >= 32'(TIMEOUT_CYCLES - 1));

  always_comb
  begin
    state_nxt  = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt  = shift_r;
    rw_nxt     = rw_r;
    bcast_nxt  = bcast_r;
    gotPtr_nxt = gotPtr_r;
    ptr_nxt    = ptr_r;
    rate_nxt   = rate_r;
    slot_nxt   = slot_r;
    txSh_nxt   = txSh_r;
    acked_nxt  = acked_r;
    if (stopDet || tmoHit)
      state_nxt = ST_IDLE;
    else if (startDet)
    begin
      state_nxt  = ST_ADDR;
      bitCnt_nxt = 4'h0;
      gotPtr_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE: ;
        ST_ADDR:
        begin
          if (sclRise)
          begin
            shift_nxt  = {shift_r[6:0], sdaLvl};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == 4'h8)
          begin
            rw_nxt    = shift_r[0];
            bcast_nxt = shift_r[7:1] == BROADCAST_GROUP_ACCESS;
            slot_nxt  = 4'h0;
            if (shift_r[7:1] == ownAddr || shift_r[7:1] == BROADCAST_GROUP_ACCESS)
              state_nxt = ST_AACK;
            else
              state_nxt = ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (sclFall)
          begin
            bitCnt_nxt = 4'h0;
            if (rw_r)
            begin
              state_nxt = ST_TX;
              txSh_nxt  = readByte(ptr_r, rate_r, tempValue);
            end
            else
              state_nxt = ST_RX;
          end
        end
        ST_RX:
        begin
          if (sclRise)
          begin
            shift_nxt  = {shift_r[6:0], sdaLvl};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == 4'h8)
          begin
            state_nxt = ST_RACK;
            if (!gotPtr_r)
            begin
              ptr_nxt    = shift_r;
              gotPtr_nxt = 1'b1;
            end
            else if (ptr_r == PTR_CFG)
              rate_nxt = {shift_r[RATE_SELECT_HIGH_BIT],
                          shift_r[RATE_SELECT_LOW_BIT]};
          end
        end
        ST_RACK:
        begin
          if (sclFall)
          begin
            state_nxt  = ST_RX;
            bitCnt_nxt = 4'h0;
          end
        end
        ST_TX:
        begin
          if (sclRise)
            bitCnt_nxt = bitCnt_r + 4'h1;
          else if (sclFall && bitCnt_r == 4'h8)
            state_nxt = ST_TACK;
          else if (sclFall)
            txSh_nxt = {txSh_r[6:0], 1'b1};
        end
        ST_TACK:
        begin
          if (sclRise)
            acked_nxt = !sdaLvl;
          else if (sclFall)
          begin
            bitCnt_nxt = 4'h0;
            if (acked_r)
            begin
              state_nxt = ST_TX;
              txSh_nxt  = readByte(ptr_r, rate_r, tempValue);
              if (slot_r != 4'hF)
                slot_nxt = slot_r + 4'h1;
            end
            else
              state_nxt = ST_IDLE;
          end
        end
      endcase
    end
    // open-drain drive: only low bits, acks, own slot
    sdaOe_nxt = (state_nxt == ST_AACK) || (state_nxt == ST_RACK) ||
                ((state_nxt == ST_TX) && ownsSlot(bcast_nxt, slot_nxt) && !txSh_nxt[7]);
    // inactivity timer restarts on any SCL edge, start or stop, and is held at zero while idle
    if (state_r == ST_IDLE || sclRise || sclFall || startDet || stopDet)
      tmo_nxt = 32'h0000_0000;
    else
      tmo_nxt = tmo_r + 32'h0000_0001;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r  <= 8'h00;
      rw_r     <= 1'b0;
      bcast_r  <= 1'b0;
      gotPtr_r <= 1'b0;
      ptr_r    <= PTR_TEMP;
      rate_r   <= RATE_RESET;
      slot_r   <= 4'h0;
      txSh_r   <= 8'hFF;
      acked_r  <= 1'b0;
      sdaOe_r  <= 1'b0;
      tmo_r    <= 32'h0000_0000;
    end
    else
    begin
      state_r  <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r  <= shift_nxt;
      rw_r     <= rw_nxt;
      bcast_r  <= bcast_nxt;
      gotPtr_r <= gotPtr_nxt;
      ptr_r    <= ptr_nxt;
      rate_r   <= rate_nxt;
      slot_r   <= slot_nxt;
      txSh_r   <= txSh_nxt;
      acked_r  <= acked_nxt;
      sdaOe_r  <= sdaOe_nxt;
      tmo_r    <= tmo_nxt;
    end
  end

  // pin drive is always low when enabled
  assign sdaOut  = 1'b0;
  assign sdaOe   = sdaOe_r;
  assign rateSel = rate_r;

  // ****************************************************
  // assertions
  // ****************************************************
  property p_idle_release;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_IDLE) |-> !sdaOe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("sda driven while idle");

  property p_start_addr;
    @(posedge clk) disable iff (!reset_n)
    (startDet && !stopDet && !tmoHit) |=> (state_r == ST_ADDR) && bitCnt_r == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start not taken");

  property p_stop_idle;
    @(posedge clk) disable iff (!reset_n)
    stopDet |=> (state_r == ST_IDLE) ##1 !sdaOe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop not taken");

  property p_ack_hold;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_RACK && sclRise) |-> sdaOe throughout (sclLvl [*2]);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack not held low");

  property p_rx_ack;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_RX && sclFall && bitCnt_r == 4'h8 && !startDet && !stopDet && !tmoHit)
      |=> (state_r == ST_RACK) && sdaOe;
  endproperty
  a_rx_ack: assert property (p_rx_ack)
    else $error("received byte not acknowledged");

  property p_nack_release;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_TACK && sclFall && !acked_r && !startDet) |=> !sdaOe && state_r == ST_IDLE;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data driven after nack");

  property p_bcast_ack;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8 && !startDet && !stopDet && !tmoHit &&
     shift_r[7:1] == BROADCAST_GROUP_ACCESS) |=> sdaOe ##1 bcast_r;
  endproperty
  a_bcast_ack: assert property (p_bcast_ack)
    else $error("broadcast byte not acknowledged");

  property p_slot_quiet;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_TX && bcast_r && slot_r != {1'b0, VARIANT_ADDR}) |-> !sdaOe;
  endproperty
  a_slot_quiet: assert property (p_slot_quiet)
    else $error("drove sda in foreign slot");

  property p_addr_match;
    @(posedge clk) disable iff (!reset_n)
    $rose(state_r == ST_AACK) |-> (shift_r[7:1] == ownAddr) || bcast_r;
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("acknowledged foreign address");

  property p_rate_reset;
    @(posedge clk) $rose(reset_n) |-> rate_r == RATE_RESET;
  endproperty
  a_rate_reset: assert property (p_rate_reset)
    else $error("rate not at reset value");

  property p_timeout;
    @(posedge clk) disable iff (!reset_n)
    tmoHit |=> (state_r == ST_IDLE) ##1 !sdaOe;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not release bus");

endmodule : tws_slave
`default_nettype wire

// ==== verif/tb_temp_sensor_two_wire_slave.sv ====
// self-checking bench of the two-wire temperature sensor slave
`timescale 1ns/10ps
`default_nettype none
module tb_temp_sensor_two_wire_slave;
  import tws_pkg::*;
  // ****************************************************
  // setup and connections
  // ****************************************************
  localparam logic [2:0]       VAR  = 3'h5;
  localparam logic [31:0]      CONV = 32'h0000_0032;
  localparam logic [31:0]      TOUT = 32'h0000_07d0;
  localparam logic [3:0][31:0] PER  = {32'h0000_00c8, 32'h0000_0190,
                                       32'h0000_0320, 32'h0000_0640};
  localparam logic [7:0]       ACK  = 8'h00;
  localparam logic [7:0]       NAK  = 8'h01;
  logic        clk;
  logic        reset_n;
  logic        scl;
  logic        mstLow;
  logic        sdaOut;
  logic        sdaOe;
  logic        sdaBus;
  logic [7:0]  tempIn;
  logic        measureOn;
  logic [7:0]  tempValue;
  logic [1:0]  rateSel;
  logic        resStb;
  logic [7:0]  resData;
  logic [31:0] rnd;
  logic [31:0] expQ[$];
  int          failures;
  int          n_tests;

  // pulled-up wire, low if anyone pulls
  assign sdaBus = ~((sdaOe & ~sdaOut) | mstLow);

  tws_slave #(.VARIANT_ADDR(VAR), .CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TOUT),
    .PERIOD_CYCLES(PER)) dut (.clk(clk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sdaBus),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .tempIn(tempIn), .measureOn(measureOn),
    .tempValue(tempValue), .rateSel(rateSel));

  tws_master_model mdl (.clk(clk), .sdaBus(sdaBus), .sclOut(scl), .sdaLow(mstLow),
    .resStb(resStb), .resData(resData));

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xorshift

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // byte out with the expected ack noted
  task automatic xfer(input logic [7:0] d, input logic [7:0] a);
    expQ.push_back(32'(a));
    mdl.sendByte(d);
  endtask : xfer

  // byte in with the expected value noted
  task automatic rd(input logic [7:0] e, input logic nack);
    expQ.push_back(32'(e));
    mdl.recvByte(nack);
  endtask : rd

  // cycles measureOn stays at level v
  task automatic runLen(input logic v, output int n);
    n = 0;
    while (measureOn === v && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : runLen

  // one full idle and conversion span
  task automatic measure(input int r);
    int g;
    int lo;
    int hi;
    runLen(1'b0, g);
    runLen(1'b1, g);
    runLen(1'b0, lo);
    runLen(1'b1, hi);
    check(32'(lo), PER[r] - CONV);
    check(32'(hi), CONV);
  endtask : measure

  // ****************************************************
  // clock, monitor, watchdog, scenarios
  // ****************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare each bus result with the oldest note
  always @(posedge clk)
    if (resStb === 1'b1)
      check(32'(resData), (expQ.size() > 0) ? expQ.pop_front() : 32'hxxxx_xxxx);

  initial
  begin
    #(60000 * 10);
    failures++;
    end_sim();
  end

  initial
  begin
    reset_n  = 1'b0;
    rnd      = 32'h0000_3ba0;
    tempIn   = 8'h00;
    failures = 0;
    n_tests  = 0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    check(32'(rateSel), 32'(RATE_RESET));
    check(32'(tempValue), 32'h0000_0000);
    check(32'(measureOn), 32'h0000_0001);
    repeat (4) @(negedge clk);
    // every rate code, multi-byte write, repeated start read
    for (int r = 0; r < 4; r++)
    begin
      rnd = xorshift(rnd);
      tempIn = rnd[7:0];
      mdl.busStart();
      xfer({DEV_ADDR_HI, VAR, 1'b0}, ACK);
      xfer(PTR_CFG, ACK);
      xfer({rnd[15], 2'(r) ^ 2'h3, rnd[12:8]}, ACK);
      xfer({rnd[23], 2'(r), rnd[20:16]}, ACK);
      mdl.busStop();
      check(32'(rateSel), 32'(r));
      measure(r);
      @(negedge clk);
      check(32'(tempValue), 32'(tempIn));
      mdl.busStart();
      xfer({DEV_ADDR_HI, VAR, 1'b0}, ACK);
      xfer(PTR_CFG, ACK);
      mdl.busStart();
      xfer({DEV_ADDR_HI, VAR, 1'b1}, ACK);
      rd({1'b0, 2'(r), 5'h00}, 1'b0);
      rd({1'b0, 2'(r), 5'h00}, 1'b1);
      mdl.busStop();
    end
    // only the fixed low address bits match
    for (int k = 0; k < 8; k++)
    begin
      mdl.busStart();
      xfer({DEV_ADDR_HI, 3'(k), 1'b0}, (3'(k) == VAR) ? ACK : NAK);
      mdl.busStop();
    end
    // stall while the slave drives a zero bit
    mdl.busStart();
    xfer({DEV_ADDR_HI, VAR, 1'b1}, ACK);
    mdl.waitN(5);
    check(32'(sdaOe), 32'h0000_0001);
    mdl.waitN(int'(TOUT) - 100);
    check(32'(sdaOe), 32'h0000_0001);
    mdl.waitN(150);
    check(32'(sdaOe), 32'h0000_0000);
    mdl.busStop();
    // broadcast write, then broadcast read of all slots
    rnd = xorshift(rnd);
    tempIn = rnd[7:0];
    mdl.busStart();
    xfer({BROADCAST_GROUP_ACCESS, 1'b0}, ACK);
    xfer(PTR_CFG, ACK);
    xfer({rnd[15], 2'h2, rnd[12:8]}, ACK);
    mdl.busStart();
    xfer({BROADCAST_GROUP_ACCESS, 1'b0}, ACK);
    xfer(PTR_TEMP, ACK);
    xfer(8'h00, ACK);
    mdl.busStop();
    check(32'(rateSel), 32'h0000_0002);
    measure(2);
    mdl.busStart();
    xfer({BROADCAST_GROUP_ACCESS, 1'b1}, ACK);
    for (int k = 0; k < 8; k++)
      rd((3'(k) == VAR) ? tempIn : 8'hff, 1'(k == 7));
    mdl.busStop();
    // addressed read of the temperature pointer
    mdl.busStart();
    xfer({DEV_ADDR_HI, VAR, 1'b1}, ACK);
    rd(tempIn, 1'b1);
    mdl.busStop();
    mdl.waitN(4);
    check(32'(expQ.size()), 32'h0000_0000);
    end_sim();
  end
endmodule : tb_temp_sensor_two_wire_slave
`default_nettype wire

// ==== verif/tws_master_model.sv ====
// two-wire bus master model that drives the sensor slave
`timescale 1ns/10ps
`default_nettype none
module tws_master_model
(
  // clock
  input  wire logic       clk,
  // bus
  input  wire logic       sdaBus,
  output logic            sclOut,
  output logic            sdaLow,
  // results seen on the bus
  output logic            resStb,
  output logic [7:0]      resData
);
  // ****************************************************
  // bus phases, 4 clk per scl half period
  // ****************************************************
  // both lines released while idle
  initial
  begin
    sclOut  = 1'b1;
    sdaLow  = 1'b0;
    resStb  = 1'b0;
    resData = 8'h00;
  end

  // wait n falling clk edges
  task automatic waitN(input int n);
    repeat (n) @(negedge clk);
  endtask : waitN

  // start or repeated start
  task automatic busStart();
    sdaLow = 1'b0;
    waitN(5);
    sclOut = 1'b1;
    waitN(4);
    sdaLow = 1'b1;
    waitN(4);
    sclOut = 1'b0;
  endtask : busStart

  // stop, then lines left released
  task automatic busStop();
    waitN(2);
    sdaLow = 1'b1;
    waitN(2);
    sclOut = 1'b1;
    waitN(4);
    sdaLow = 1'b0;
    waitN(4);
  endtask : busStop

  // one bit slot; unstable data in scl high reads unknown
  task automatic bitXfer(input logic b, output logic r);
    logic s1;
    waitN(2);
    sdaLow = ~b;
    waitN(2);
    sclOut = 1'b1;
    waitN(1);
    s1 = sdaBus;
    waitN(3);
    r = (s1 === sdaBus) ? s1 : 1'bx;
    sclOut = 1'b0;
  endtask : bitXfer

  // hand one result to the bench
  task automatic report(input logic [7:0] v);
    resData = v;
    resStb  = 1'b1;
    waitN(1);
    resStb  = 1'b0;
  endtask : report

  // send a byte and report the ack bit
  task automatic sendByte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitXfer(d[i], r);
    bitXfer(1'b1, r);
    report({7'h00, r});
  endtask : sendByte

  // receive a byte, then ack or nack it
  task automatic recvByte(input logic nack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--)
      bitXfer(1'b1, d[i]);
    bitXfer(nack, r);
    report(d);
  endtask : recvByte
endmodule : tws_master_model
`default_nettype wire
